// [rtl/ulmcs_top.sv]
// top: line format, modem control, line status and modem status of one channel
`timescale 1ns/1ns

module ulmcs_top (
  input  wire logic                     ref_clk,
  input  wire logic                     rst_b,
  input  wire logic [ulmcs_pkg::AW-1:0] reg_addr,
  input  wire logic [ulmcs_pkg::DW-1:0] reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [ulmcs_pkg::DW-1:0] reg_rdata,
  input  wire logic                     serial_in,
  output logic                          serial_out,
  input  wire logic                     clear_to_send_in_n,
  input  wire logic                     data_set_ready_in_n,
  input  wire logic                     ring_indicator_in_n,
  input  wire logic                     carrier_detect_in_n,
  output logic                          terminal_ready_out_n,
  output logic                          request_to_send_out_n,
  output logic                          general_output_two_n,
  output logic                          irq_out,
  output logic                          irq_oe
);
  import ulmcs_pkg::*;

  // software registers
  logic [7:0]  lfc_r;
  logic [4:0]  moc_r;
  logic [3:0]  ien_r;
  logic [15:0] div_r;

  // pin synchronisers: {cd, ri, dsr, cts, rx}
  logic [4:0]  sync1_r;
  logic [4:0]  sync2_r;

  // transmit side
  logic [7:0]  thr_r;
  logic        thr_full_r;
  logic        tx_busy_r;
  logic [10:0] tx_sh_r;
  logic [3:0]  tx_left_r;
  logic [15:0] tx_cnt_r;

  // receive holding register and its tags
  logic [7:0]  rhr_r;
  logic        rx_full_r;
  logic        perr_r;
  logic        ferr_r;
  logic        brk_r;
  logic        ovr_r;
  logic        ls_pend_r;

  // modem status history
  logic [3:0]  ms_r;
  logic [3:0]  delta_r;
  logic [1:0]  prime_r;
  logic [3:0]  ms_hit;

  // output flops
  logic        serial_out_r;
  logic        term_n_r;
  logic        rts_n_r;
  logic        op2_n_r;
  logic        irq_r;
  logic        irq_oe_r;
  logic [7:0]  rdata_r;

  ulmcs_rx_if rxc ();

  // mode bits
  wire dlab = lfc_r[LF_DIV];
  wire loop = moc_r[MO_LOOP];

  // address decode; divisor access swaps the low two slots
  wire hit_data = (reg_addr == OFS_DATA);
  wire hit_ien  = (reg_addr == OFS_IEN);
  wire wr_data  = reg_wr & hit_data & ~dlab;
  wire wr_dll   = reg_wr & hit_data & dlab;
  wire wr_ien   = reg_wr & hit_ien & ~dlab;
  wire wr_dlm   = reg_wr & hit_ien & dlab;
  wire wr_lfc   = reg_wr & (reg_addr == OFS_LFC);
  wire wr_moc   = reg_wr & (reg_addr == OFS_MOC);
  wire rd_data  = reg_rd & hit_data & ~dlab;
  wire rd_lst   = reg_rd & (reg_addr == OFS_LST);
  wire rd_mis   = reg_rd & (reg_addr == OFS_MIS);

  // a zero divisor would stall both shifters, so it counts as one
  wire [15:0] bit_cyc = (div_r == 16'h0000) ? 16'h0001 : div_r;
  wire [15:0] bit_m1  = bit_cyc - 16'h0001;

  // transmit framing
  wire        tx_bit_end = (tx_cnt_r == 16'h0000);
  wire        tx_take    = ~tx_busy_r & thr_full_r;
  wire        tx_par     = ulmcs_par_bit(thr_r, lfc_r[LF_EVEN], lfc_r[LF_FORCE]);
  wire [10:0] tx_frame   = lfc_r[LF_PAR_EN] ? {1'h1, tx_par, thr_r, 1'h0}
                                            : {2'h3, thr_r, 1'h0};
  wire [3:0]  tx_len     = lfc_r[LF_PAR_EN] ? TX_LEN_PAR : TX_LEN_NOPAR;
  wire        tx_line    = ~tx_busy_r | tx_sh_r[0];
  wire        tx_int     = tx_line & ~lfc_r[LF_BREAK];
  wire        thr_full_nxt = wr_data | (thr_full_r & ~tx_take);

  // receiver source: pin after sync, or our own transmit line in loopback
  wire rx_src = loop ? tx_int : sync2_r[0];

  // receive holding: a new character against a full holder is dropped unless that holder is read in the same cycle
  wire rx_done   = rxc.done;
  wire rx_ovr    = rx_done & rx_full_r & ~rd_data;
  wire rx_load   = rx_done & ~rx_ovr;
  wire rx_tag    = rxc.perr | rxc.ferr | rxc.brk;
  wire rx_full_nxt = rx_load | (rx_full_r & ~rd_data);

  // line status bits
  wire thre    = ~thr_full_r;
  wire temt    = thre & ~tx_busy_r;
  wire err_any = perr_r | ferr_r | brk_r;
  wire [7:0] lst_val = {err_any, temt, thre, brk_r, ferr_r, perr_r, ovr_r, rx_full_r};

  // modem status: pins inverted, or loop from control bits
  wire [3:0] ms_pin  = ~sync2_r[4:1];
  wire [3:0] ms_loop = {moc_r[MO_INT_EN], moc_r[MO_AUX1], moc_r[MO_TERM], moc_r[MO_REQ]};
  wire [3:0] ms_now  = loop ? ms_loop : ms_pin;
  wire       primed  = (prime_r == PRIME_CYC);
  wire [7:0] mis_val = {ms_now, delta_r};

  // per-input change detectors; ring only counts the end of ringing
  for (genvar i = 0; i < 4; i++) begin : g_delta
    if (i == 2) begin : g_ring
      assign ms_hit[i] = primed & ms_r[i] & ~ms_now[i];
    end else begin : g_any
      assign ms_hit[i] = primed & (ms_r[i] ^ ms_now[i]);
    end
  end

  // interrupt request from enabled sources
  wire irq_nxt = (ien_r[IE_RX] & rx_full_r)
               | (ien_r[IE_THRE] & thre)
               | (ien_r[IE_LS] & ls_pend_r)
               | (ien_r[IE_MS] & (|delta_r));

  // read data selection; reserved bits and holes read zero
  wire [7:0] rd_mux =
      hit_data                 ? (dlab ? div_r[7:0]  : rhr_r)          :
      hit_ien                  ? (dlab ? div_r[15:8] : {4'h0, ien_r})  :
      (reg_addr == OFS_LFC)    ? lfc_r                                 :
      (reg_addr == OFS_MOC)    ? {3'h0, moc_r}                         :
      (reg_addr == OFS_LST)    ? lst_val                               :
      (reg_addr == OFS_MIS)    ? mis_val                               :
                                 8'h00;

  // receiver configuration
  assign rxc.bit_cyc  = bit_cyc;
  assign rxc.par_en   = lfc_r[LF_PAR_EN];
  assign rxc.par_even = lfc_r[LF_EVEN];
  assign rxc.par_frc  = lfc_r[LF_FORCE];

  ulmcs_rx i_ulmcs_rx (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .rx_line (rx_src),
    .cfg     (rxc)
  );

  // two-stage synchronisers; idle level of every pin is high
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r <= 5'h1f;
      sync2_r <= 5'h1f;
    end else begin
      sync1_r <= {carrier_detect_in_n, ring_indicator_in_n, data_set_ready_in_n,
                  clear_to_send_in_n, serial_in};
      sync2_r <= sync1_r;
    end
  end

  // software-written registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lfc_r <= LFC_RST;
      moc_r <= MOC_RST;
      ien_r <= IEN_RST;
      div_r <= DIV_RST;
    end else begin
      if (wr_lfc) lfc_r <= reg_wdata;
      if (wr_moc) moc_r <= reg_wdata[4:0];
      if (wr_ien) ien_r <= reg_wdata[3:0];
      if (wr_dll) div_r[7:0] <= reg_wdata;
      if (wr_dlm) div_r[15:8] <= reg_wdata;
    end
  end

  // holding register; a write in the cycle of the move keeps it full
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      thr_r      <= 8'h00;
      thr_full_r <= 1'b0;
    end else begin
      if (wr_data) thr_r <= reg_wdata;
      thr_full_r <= thr_full_nxt;
    end
  end

  // transmit shifter, lsb first, one bit per bit_cyc cycles
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_busy_r <= 1'b0;
      tx_sh_r   <= 11'h7ff;
      tx_left_r <= 4'h0;
      tx_cnt_r  <= 16'h0000;
    end else if (tx_take) begin
      tx_busy_r <= 1'b1;
      tx_sh_r   <= tx_frame;
      tx_left_r <= tx_len;
      tx_cnt_r  <= bit_m1;
    end else if (tx_busy_r && tx_bit_end) begin
      tx_busy_r <= (tx_left_r != 4'h1);
      tx_sh_r   <= {1'h1, tx_sh_r[10:1]};
      tx_left_r <= tx_left_r - 4'h1;
      tx_cnt_r  <= bit_m1;
    end else if (tx_busy_r) begin
      tx_cnt_r  <= tx_cnt_r - 16'h0001;
    end
  end

  // receive holding and its error tags travel with the character
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rhr_r     <= 8'h00;
      rx_full_r <= 1'b0;
      perr_r    <= 1'b0;
      ferr_r    <= 1'b0;
      brk_r     <= 1'b0;
    end else begin
      rx_full_r <= rx_full_nxt;
      if (rx_load) begin
        rhr_r  <= rxc.data;
        perr_r <= rxc.perr;
        ferr_r <= rxc.ferr;
        brk_r  <= rxc.brk;
      end else if (rd_data) begin
        perr_r <= 1'b0;
        ferr_r <= 1'b0;
        brk_r  <= 1'b0;
      end
    end
  end

  // sticky overrun and line interrupt; a new event beats the clearing read
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ovr_r     <= 1'b0;
      ls_pend_r <= 1'b0;
    end else begin
      ovr_r     <= rx_ovr | (ovr_r & ~rd_lst);
      ls_pend_r <= rx_ovr | (rx_load & rx_tag) | (ls_pend_r & ~rd_lst);
    end
  end

  // modem history; deltas are held off until the synchronisers settle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ms_r    <= 4'h0;
      delta_r <= 4'h0;
      prime_r <= 2'h0;
    end else begin
      ms_r    <= ms_now;
      delta_r <= ms_hit | (delta_r & {4{~rd_mis}});
      if (!primed) prime_r <= prime_r + 2'h1;
    end
  end

  // pin drivers; loopback parks all four of these pins at their idle level
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      serial_out_r <= 1'b1;
      term_n_r     <= 1'b1;
      rts_n_r      <= 1'b1;
      op2_n_r      <= 1'b1;
    end else begin
      serial_out_r <= loop | tx_int;
      term_n_r     <= loop | ~moc_r[MO_TERM];
      rts_n_r      <= loop | ~moc_r[MO_REQ];
      op2_n_r      <= loop | ~moc_r[MO_INT_EN];
    end
  end

  // interrupt pin and read data
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_r    <= 1'b0;
      irq_oe_r <= 1'b0;
      rdata_r  <= 8'h00;
    end else begin
      irq_r    <= irq_nxt;
      irq_oe_r <= moc_r[MO_INT_EN];
      rdata_r  <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata             = rdata_r;
  assign serial_out            = serial_out_r;
  assign terminal_ready_out_n  = term_n_r;
  assign request_to_send_out_n = rts_n_r;
  assign general_output_two_n  = op2_n_r;
  assign irq_out               = irq_r;
  assign irq_oe                = irq_oe_r;

endmodule : ulmcs_top

// [common/ulmcs_pkg.sv]
// package: register map, fields, reset values and states of the line/modem block
package ulmcs_pkg;

  localparam int unsigned AW        = 3;
  localparam int unsigned DW        = 8;
  localparam int unsigned DATA_BITS = 8;

  // register offsets; data and enable share their slots with the divisor
  localparam logic [AW-1:0] OFS_DATA = 3'h0;
  localparam logic [AW-1:0] OFS_IEN  = 3'h1;
  localparam logic [AW-1:0] OFS_LFC  = 3'h3;
  localparam logic [AW-1:0] OFS_MOC  = 3'h4;
  localparam logic [AW-1:0] OFS_LST  = 3'h5;
  localparam logic [AW-1:0] OFS_MIS  = 3'h6;

  // line_format_control fields
  localparam int LF_PAR_EN = 3;
  localparam int LF_EVEN   = 4;
  localparam int LF_FORCE  = 5;
  localparam int LF_BREAK  = 6;
  localparam int LF_DIV    = 7;

  // modem_output_control fields
  localparam int MO_TERM   = 0;
  localparam int MO_REQ    = 1;
  localparam int MO_AUX1   = 2;
  localparam int MO_INT_EN = 3;
  localparam int MO_LOOP   = 4;

  // interrupt_enable_reg fields
  localparam int IE_RX   = 0;
  localparam int IE_THRE = 1;
  localparam int IE_LS   = 2;
  localparam int IE_MS   = 3;

  // values after reset
  localparam logic [7:0]  LFC_RST = 8'h00;
  localparam logic [4:0]  MOC_RST = 5'h00;
  localparam logic [3:0]  IEN_RST = 4'h0;
  localparam logic [15:0] DIV_RST = 16'h0010;

  // frame lengths in bits: start, data, optional parity, stop
  localparam logic [3:0] TX_LEN_PAR   = 4'hb;
  localparam logic [3:0] TX_LEN_NOPAR = 4'ha;
  // cycles after reset before modem deltas are armed
  localparam logic [1:0] PRIME_CYC    = 2'h3;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_MARK} ulmcs_rx_st_type;

  // parity bit for a character; forced mode ignores the data
  function automatic logic ulmcs_par_bit(input logic [7:0] d, input logic even,
                                         input logic frc);
    ulmcs_par_bit = frc ? ~even : (even ? ^d : ~^d);
  endfunction : ulmcs_par_bit

endpackage : ulmcs_pkg

// [common/ulmcs_rx_if.sv]
// interface: receiver configuration and received-character results
`timescale 1ns/1ns
interface ulmcs_rx_if;
  logic [15:0] bit_cyc;
  logic        par_en;
  logic        par_even;
  logic        par_frc;
  logic        done;
  logic [7:0]  data;
  logic        perr;
  logic        ferr;
  logic        brk;

  modport ctl (output bit_cyc, par_en, par_even, par_frc,
               input  done, data, perr, ferr, brk);
  modport rx  (input  bit_cyc, par_en, par_even, par_frc,
               output done, data, perr, ferr, brk);
endinterface : ulmcs_rx_if

// [rtl/ulmcs_rx.sv]
// serial receiver: start detect, mid-bit sampling, parity, framing and break
`timescale 1ns/1ns
module ulmcs_rx (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic rx_line,
  ulmcs_rx_if.rx   cfg
);
  import ulmcs_pkg::*;

  ulmcs_rx_st_type st_r;
  logic [15:0]     cnt_r;
  logic [3:0]      idx_r;
  logic [8:0]      frm_r;
  logic            done_r;
  logic [7:0]      data_r;
  logic            perr_r;
  logic            ferr_r;
  logic            brk_r;

  // bit timing and end-of-frame checks
  wire        cnt_end  = (cnt_r == 16'h0000);
  wire [3:0]  last_idx = cfg.par_en ? 4'h9 : 4'h8;
  wire [15:0] half     = (cfg.bit_cyc[15:1] == 15'h0000) ? 16'h0000 // start seen late, so aim early
                       : {1'b0, cfg.bit_cyc[15:1]} - 16'h0001;
  wire [15:0] full_m1  = cfg.bit_cyc - 16'h0001;
  wire        exp_par  = ulmcs_par_bit(frm_r[7:0], cfg.par_even, cfg.par_frc);
  wire        perr_w   = cfg.par_en & (frm_r[8] != exp_par);
  wire        brk_w    = (frm_r[7:0] == 8'h00) & ~(cfg.par_en & frm_r[8]) & ~rx_line;

  // one state machine walks the frame; a low stop bit waits for mark again
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r   <= RX_IDLE;
      cnt_r  <= 16'h0000;
      idx_r  <= 4'h0;
      frm_r  <= 9'h000;
      done_r <= 1'b0;
      data_r <= 8'h00;
      perr_r <= 1'b0;
      ferr_r <= 1'b0;
      brk_r  <= 1'b0;
    end else begin
      done_r <= 1'b0;
      unique case (st_r)
        RX_IDLE: begin
          cnt_r <= half;
          if (!rx_line) st_r <= RX_START;
        end
        RX_START: begin
          if (!cnt_end) cnt_r <= cnt_r - 16'h0001;
          else if (rx_line) st_r <= RX_IDLE; // glitch shorter than half a bit
          else begin
            st_r  <= RX_BITS;
            cnt_r <= full_m1;
            idx_r <= 4'h0;
          end
        end
        RX_BITS: begin
          if (!cnt_end) cnt_r <= cnt_r - 16'h0001;
          else if (idx_r != last_idx) begin
            frm_r[idx_r] <= rx_line;
            idx_r        <= idx_r + 4'h1;
            cnt_r        <= full_m1;
          end else begin
            done_r <= 1'b1;
            data_r <= frm_r[7:0];
            perr_r <= perr_w;
            ferr_r <= ~rx_line;
            brk_r  <= brk_w;
            st_r   <= rx_line ? RX_IDLE : RX_MARK;
          end
        end
        RX_MARK: if (rx_line) st_r <= RX_IDLE;
      endcase
    end
  end

  assign cfg.done = done_r;
  assign cfg.data = data_r;
  assign cfg.perr = perr_r;
  assign cfg.ferr = ferr_r;
  assign cfg.brk  = brk_r;

endmodule : ulmcs_rx

// [testbench/ulmcs_properties.sv]
// checker: port relations of the line and modem status block
`timescale 1ns/1ns
module ulmcs_properties (
  input wire logic                     ref_clk,
  input wire logic                     rst_b,
  input wire logic [ulmcs_pkg::AW-1:0] reg_addr,
  input wire logic [ulmcs_pkg::DW-1:0] reg_wdata,
  input wire logic                     reg_wr,
  input wire logic                     reg_rd,
  input wire logic [ulmcs_pkg::DW-1:0] reg_rdata,
  input wire logic                     serial_out,
  input wire logic                     terminal_ready_out_n,
  input wire logic                     request_to_send_out_n,
  input wire logic                     irq_oe
);
  import ulmcs_pkg::*;
  logic [7:0] moc_r;

  // shadow of the last modem control write; pins must follow it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      moc_r <= 8'h00;
    end else if (reg_wr && reg_addr == OFS_MOC) begin
      moc_r <= reg_wdata;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // bus steps that start each relation
  sequence s_moc_wr;
    reg_wr && reg_addr == OFS_MOC;
  endsequence
  sequence s_brk_wr;
    reg_wr && reg_addr == OFS_LFC && reg_wdata[LF_BREAK];
  endsequence
  sequence s_rd_done(logic [2:0] a);
    $past(reg_rd) && $past(reg_addr) == a;
  endsequence

  term_req_a: assert property (s_moc_wr |-> ##2
    terminal_ready_out_n == !(moc_r[0] && !moc_r[4])
    && request_to_send_out_n == !(moc_r[1] && !moc_r[4]))
    else $error("terminal or request pin off its control bit");
  int_oe_a: assert property (s_moc_wr |-> ##2 irq_oe == moc_r[3])
    else $error("interrupt enable off control bit 3");
  break_hold_a: assert property (s_brk_wr |-> ##2 !serial_out [*4])
    else $error("transmit pin not held at space");
  loop_idle_a: assert property (s_moc_wr ##0 reg_wdata[MO_LOOP] |-> ##2
    (serial_out && terminal_ready_out_n && request_to_send_out_n) [*3])
    else $error("pins not idle in loopback");
  tx_empty_a: assert property (s_rd_done(OFS_LST) ##0 reg_rdata[6] |-> reg_rdata[5])
    else $error("transmitter empty without holding empty");
  err_sum_a: assert property (s_rd_done(OFS_LST) ##0 reg_rdata[7] |-> reg_rdata[0])
    else $error("error summary with nothing held");
  break_flag_a: assert property (s_rd_done(OFS_LST) ##0 reg_rdata[4]
    |-> reg_rdata[0] && reg_rdata[3])
    else $error("break flag without its character");
  loop_status_a: assert property (s_rd_done(OFS_MIS) ##0 moc_r[4]
    |-> reg_rdata[7:4] == {moc_r[3], moc_r[2], moc_r[0], moc_r[1]})
    else $error("loopback modem status off control bits");
endmodule : ulmcs_properties

bind ulmcs_top ulmcs_properties i_ulmcs_properties (.ref_clk, .rst_b, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .serial_out, .terminal_ready_out_n,
  .request_to_send_out_n, .irq_oe);

// [testbench/ulmcs_modem_model.sv]
// partner model: far-end serial sender and modem handshake lines
`timescale 1ns/1ns
module ulmcs_modem_model (
  input  wire logic       ref_clk,
  output logic            ser_line,
  output logic [3:0]      mdm_n
);
  // idle: line at mark, handshake lines inactive
  initial begin
    ser_line = 1'b1;
    mdm_n    = 4'hf;
  end
  // one frame lsb first at 4 cycles a bit; bad parity or stop is the caller's choice
  task automatic send(input logic [7:0] d, input logic pe, input logic p, input logic s);
    logic [10:0] f;
    f = pe ? {s, p, d, 1'b0} : {1'b1, s, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge ref_clk);
      ser_line <= f[i];
      repeat (3) @(posedge ref_clk);
    end
    @(posedge ref_clk);
    ser_line <= 1'b1;
  endtask : send
  // line held at space for n cycles, then back to mark
  task automatic hold_low(input int n);
    @(posedge ref_clk);
    ser_line <= 1'b0;
    repeat (n) @(posedge ref_clk);
    ser_line <= 1'b1;
  endtask : hold_low
  // bits: 0 clear-to-send, 1 data-set-ready, 2 ring, 3 carrier
  task automatic set_mdm(input logic [3:0] v);
    @(posedge ref_clk);
    mdm_n <= v;
  endtask : set_mdm
endmodule : ulmcs_modem_model

// [testbench/ulmcs_bench.sv]
// testbench: register, pin and serial scenarios of the line and modem block
`timescale 1ns/1ns
module ulmcs_bench;
  import ulmcs_pkg::*;
  logic          ref_clk;
  logic          rst_b;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata;
  logic [DW-1:0] reg_rdata;
  logic          reg_wr;
  logic          reg_rd;
  logic          serial_in;
  logic          serial_out;
  logic [3:0]    mdm_n;
  logic          terminal_ready_out_n;
  logic          request_to_send_out_n;
  logic          general_output_two_n;
  logic          irq_out;
  logic          irq_oe;
  logic [3:0]    pins;
  int            err_total = 0;
  int            n_compared = 0;
  int            cyc = 0;

  assign pins = {serial_out, terminal_ready_out_n, request_to_send_out_n, general_output_two_n};

  ulmcs_top i_ulmcs_top (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .serial_in, .serial_out, .clear_to_send_in_n(mdm_n[0]),
    .data_set_ready_in_n(mdm_n[1]), .ring_indicator_in_n(mdm_n[2]),
    .carrier_detect_in_n(mdm_n[3]), .terminal_ready_out_n, .request_to_send_out_n,
    .general_output_two_n, .irq_out, .irq_oe);
  ulmcs_modem_model i_ulmcs_modem_model (.ref_clk, .ser_line(serial_in), .mdm_n);

  // clock and hang guard; scenarios need about a thousand cycles
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  // comparison, bus cycles and verdict
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    v = reg_rdata;
  endtask : rd
  task automatic rdchk(input logic [2:0] a, input logic [7:0] e, input string nm);
    logic [7:0] v;
    rd(a, v);
    chk(nm, e, v);
  endtask : rdchk
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // receive one frame from the far end, then take the character out
  task automatic rx_char(input logic [7:0] d, input logic pe, input logic p, input logic s);
    i_ulmcs_modem_model.send(d, pe, p, s);
    repeat (6) @(posedge ref_clk);
  endtask : rx_char
  task automatic rx_take(input logic [7:0] d);
    rdchk(OFS_DATA, d, "rx_data");
    rdchk(OFS_LST, 8'h60, "rx_drained");
  endtask : rx_take

  // reset values, spare offsets and pins
  task automatic t_reset;
    rdchk(OFS_LFC, 8'h00, "lfc_rst");
    rdchk(OFS_MOC, 8'h00, "moc_rst");
    rdchk(OFS_LST, 8'h60, "lst_rst");
    rdchk(OFS_MIS, 8'h00, "mis_rst");
    rdchk(3'h2, 8'h00, "spare_2");
    rdchk(3'h7, 8'h00, "spare_7");
    chk("pins_rst", 6'h3c, {pins, irq_oe, irq_out});
  endtask : t_reset
  // control pins and divisor window
  task automatic t_ctrl;
    wr(OFS_MOC, 8'h03);
    rdchk(OFS_MOC, 8'h03, "moc_rw");
    chk("pins_on", 4'h9, pins);
    wr(OFS_MOC, 8'h08);
    repeat (2) @(posedge ref_clk);
    chk("int_side", 5'h1d, {pins, irq_oe});
    wr(OFS_IEN, 8'h04);
    wr(OFS_LFC, 8'h80);
    rdchk(OFS_DATA, 8'h10, "div_lo");
    rdchk(OFS_IEN, 8'h00, "div_hi");
    wr(OFS_DATA, 8'h04);
    rdchk(OFS_DATA, 8'h04, "div_lo_wr");
    wr(OFS_LFC, 8'h00);
    rdchk(OFS_IEN, 8'h04, "ien_back");
  endtask : t_ctrl
  // every parity mode on a character with three ones
  task automatic t_tx;
    logic [7:0]  mode [5] = '{8'h00, 8'h08, 8'h18, 8'h28, 8'h38};
    logic        pbit [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [10:0] f;
    for (int m = 0; m < 5; m++) begin
      wr(OFS_LFC, mode[m]);
      wr(OFS_DATA, 8'h52);
      rdchk(OFS_LST, 8'h20, "tx_busy");
      for (int i = 0; i < 200 && serial_out; i++) @(posedge ref_clk);
      repeat (2) @(posedge ref_clk);
      for (int k = 0; k < 11; k++) begin
        f[k] = serial_out;
        repeat (4) @(posedge ref_clk);
      end
      chk("tx_frame", {1'b1, pbit[m], 8'h52, 1'b0}, f);
      repeat (8) @(posedge ref_clk);
      rdchk(OFS_LST, 8'h60, "tx_idle");
    end
    wr(OFS_LFC, 8'h40);
    repeat (30) @(posedge ref_clk);
    chk("brk_low", 1'b0, serial_out);
    wr(OFS_LFC, 8'h00);
    repeat (3) @(posedge ref_clk);
    chk("brk_end", 1'b1, serial_out);
  endtask : t_tx
  // good, parity-bad, frame-bad and break characters
  task automatic t_rx;
    wr(OFS_LFC, 8'h08);
    rx_char(8'h52, 1'b1, 1'b0, 1'b1);
    rdchk(OFS_LST, 8'h61, "rx_ready");
    rx_take(8'h52);
    rx_char(8'h52, 1'b1, 1'b1, 1'b1);
    chk("par_irq", 1'b1, irq_out);
    rdchk(OFS_LST, 8'he5, "par_err");
    rx_take(8'h52);
    rx_char(8'h52, 1'b1, 1'b0, 1'b0);
    chk("frm_irq", 1'b1, irq_out);
    rdchk(OFS_LST, 8'he9, "frm_err");
    rx_take(8'h52);
    wr(OFS_LFC, 8'h00);
    i_ulmcs_modem_model.hold_low(100);
    repeat (10) @(posedge ref_clk);
    rdchk(OFS_LST, 8'hf9, "brk_flag");
    rx_take(8'h00);
  endtask : t_rx
  // overrun with line interrupt, then receive and holding-empty interrupts
  task automatic t_intr;
    rx_char(8'h11, 1'b0, 1'b0, 1'b1);
    rx_char(8'h22, 1'b0, 1'b0, 1'b1);
    chk("ovr_irq", 1'b1, irq_out);
    rdchk(OFS_LST, 8'h63, "ovr_flag");
    @(posedge ref_clk);
    chk("ls_irq_clr", 1'b0, irq_out);
    rdchk(OFS_LST, 8'h61, "ovr_clr");
    wr(OFS_IEN, 8'h01);
    repeat (2) @(posedge ref_clk);
    chk("rx_irq", 1'b1, irq_out);
    rx_take(8'h11);
    wr(OFS_IEN, 8'h02);
    repeat (2) @(posedge ref_clk);
    chk("thre_irq", 1'b1, irq_out);
  endtask : t_intr
  // modem line changes, deltas and their interrupt
  task automatic t_modem;
    logic [3:0] lv [4] = '{4'he, 4'ha, 4'h4, 4'hf};
    logic [7:0] ex [4] = '{8'h11, 8'h50, 8'hbe, 8'h0b};
    wr(OFS_IEN, 8'h08);
    for (int i = 0; i < 4; i++) begin
      i_ulmcs_modem_model.set_mdm(lv[i]);
      repeat (6) @(posedge ref_clk);
      chk("ms_irq", i != 1, irq_out);
      rdchk(OFS_MIS, ex[i], "mis_delta");
      @(posedge ref_clk);
      chk("ms_irq_clr", 1'b0, irq_out);
      rdchk(OFS_MIS, {ex[i][7:4], 4'h0}, "mis_clr");
    end
  endtask : t_modem
  // loopback: status from control bits, pins idle, data turned round
  task automatic t_loop;
    logic [7:0] v;
    wr(OFS_MOC, 8'h1f);
    repeat (3) @(posedge ref_clk);
    chk("loop_pins", 5'h1f, {pins, irq_oe});
    rd(OFS_MIS, v);
    rdchk(OFS_MIS, 8'hf0, "loop_mis");
    wr(OFS_MOC, 8'h12);
    rd(OFS_MIS, v);
    rdchk(OFS_MIS, 8'h10, "loop_req");
    wr(OFS_DATA, 8'h3c);
    repeat (10) @(posedge ref_clk);
    chk("loop_tx_idle", 1'b1, serial_out);
    repeat (60) @(posedge ref_clk);
    rdchk(OFS_LST, 8'h61, "loop_lst");
    rdchk(OFS_DATA, 8'h3c, "loop_data");
    wr(OFS_MOC, 8'h00);
  endtask : t_loop

  // main sequence
  initial begin
    rst_b     = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 3'h0;
    reg_wdata = 8'h00;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_ctrl();
    t_tx();
    t_rx();
    t_intr();
    t_modem();
    t_loop();
    wrap_up();
  end
endmodule : ulmcs_bench
